/* File: rtl/byte_aligner.sv */
`timescale 1ns/1ps

module byte_aligner (
    input  wire logic       clk,
    input  wire logic       resetn,
    rxcfg_if.user           cfg,
    input  wire logic       bit_in,
    input  wire logic       bit_valid,
    output logic [7:0]      byte_out,
    output logic            byte_valid
);

    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       lock_r;
    logic       lock_nxt;
    logic       locked;
    logic       take;

    // Without alignment the byte grid starts at init release
    assign locked = lock_r || !cfg.bae;
    assign take   = !cfg.clear && bit_valid
                    && cfg.mode == rxcfg_pkg::RX_MODE_TRANSP;

    always_comb begin
        sh_nxt     = sh_r;
        cnt_nxt    = cnt_r;
        lock_nxt   = lock_r;
        byte_out   = 8'h00;
        byte_valid = 1'b0;
        if (cfg.clear) begin
            sh_nxt   = 8'h00;
            cnt_nxt  = 3'h0;
            lock_nxt = 1'b0;
        end else if (take) begin
            sh_nxt = {bit_in, sh_r[7:1]};
            if (!locked) begin
                if (sh_nxt == cfg.pattern) begin // [RQ2] [RQ3]
                    lock_nxt = 1'b1;
                    cnt_nxt  = 3'h0;
                end
            end else begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == 3'h7) begin
                    byte_out   = sh_nxt;
                    byte_valid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_r   <= 8'h00;
            cnt_r  <= 3'h0;
            lock_r <= 1'b0;
        end else if (cfg.ce) begin
            sh_r   <= sh_nxt;
            cnt_r  <= cnt_nxt;
            lock_r <= lock_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_hunt_silent: assert property ( // [RQ2]
        cfg.bae && !lock_r |-> !byte_valid)
        else $error("Byte emitted while still hunting for alignment");

    chk_pattern_lock: assert property ( // [RQ3]
        cfg.ce && take && cfg.bae && !lock_r
        && {bit_in, sh_r[7:1]} == cfg.pattern |=> lock_r)
        else $error("Alignment pattern matched but no lock");

endmodule

/* File: rtl/crc_trimmer.sv */
`timescale 1ns/1ps
`include "rxcfg_defs.svh"

module crc_trimmer (
    input  wire logic       clk,
    input  wire logic       resetn,
    rxcfg_if.user           cfg,
    input  wire logic [7:0] byte_in,
    input  wire logic       byte_in_valid,
    input  wire logic       frame_end,
    output logic [7:0]      byte_out,
    output logic            byte_valid
);

    localparam logic [1:0] HOLD = 2'(`RXC_CRC_BYTES);

    logic [7:0] new_r;
    logic [7:0] new_nxt;
    logic [7:0] old_r;
    logic [7:0] old_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       hdlc;

    assign hdlc = !cfg.clear && cfg.mode == rxcfg_pkg::RX_MODE_HDLC;

    // With drop set, the last two bytes are always held back
    always_comb begin
        new_nxt    = new_r;
        old_nxt    = old_r;
        cnt_nxt    = cnt_r;
        byte_out   = 8'h00;
        byte_valid = 1'b0;
        if (cfg.clear) begin
            cnt_nxt = 2'h0;
        end else if (hdlc && frame_end) begin
            cnt_nxt = 2'h0; // [RQ4]
        end else if (hdlc && byte_in_valid) begin
            if (!cfg.drop) begin
                byte_out   = byte_in; // [RQ4]
                byte_valid = 1'b1;
            end else begin
                if (cnt_r == HOLD) begin
                    byte_out   = old_r;
                    byte_valid = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 2'h1;
                end
                old_nxt = new_r;
                new_nxt = byte_in;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            new_r <= 8'h00;
            old_r <= 8'h00;
            cnt_r <= 2'h0;
        end else if (cfg.ce) begin
            new_r <= new_nxt;
            old_r <= old_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_crc_discard: assert property ( // [RQ4]
        cfg.drop && cnt_r != HOLD |-> !byte_valid)
        else $error("Byte released before two were held back");

    chk_frame_flush: assert property ( // [RQ4]
        cfg.ce && hdlc && frame_end |=> cnt_r == 2'h0)
        else $error("Held check bytes survived end of frame");

endmodule

/* File: rtl/hdlc_receiver_config_init.sv */
`timescale 1ns/1ps
`include "rxcfg_defs.svh"

// Overview of operation
// [RQ1] Mode bit picks HDLC or transparent
// [RQ2] Alignment only with enable set, transparent
// [RQ3] Alignment pattern comes from register 22h
// [RQ4] Drop bit discards both frame check bytes
// [RQ5] Writing one starts init; zero does nothing
// [RQ6] Receiver initializes itself after power-up
// [RQ7] Init bit reads one until done
// [RQ8] Firmware reinitializes after any setting change
// [RQ9] Firmware initializes and polls before programming
// [RQ10] Drop setting frozen between initializations
// [RQ11] Firmware writes zero to upper bits
module hdlc_receiver_config_init #(
    parameter int INIT_CYCLES = `RXC_INIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       rx_bit,
    input  wire logic       rx_bit_valid,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_byte_valid,
    input  wire logic       rx_frame_end,
    output logic [7:0]      fifo_wdata,
    output logic            fifo_wr,
    output logic            rx_init_busy
);

    localparam int         CW       = (INIT_CYCLES > 1) ?
                                      $clog2(INIT_CYCLES) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(INIT_CYCLES - 1);
    localparam logic [7:0] CFG_RST  = `RXC_CFG_RESET;
    localparam logic [7:0] PAT_RST  = `RXC_PAT_RESET;

    // Software-visible settings
    rxcfg_pkg::rx_mode_e      mode_r;
    rxcfg_pkg::rx_mode_e      mode_nxt;
    logic                     bae_r;
    logic                     bae_nxt;
    logic                     drop_r;
    logic                     drop_nxt;
    logic [7:0]               pat_r;
    logic [7:0]               pat_nxt;

    // Init sequencer
    rxcfg_pkg::init_state_e   state_r;
    rxcfg_pkg::init_state_e   state_nxt;
    logic [CW-1:0]            cnt_r;
    logic [CW-1:0]            cnt_nxt;
    logic                     busy;
    logic                     cfg_wr;
    logic                     pat_wr;
    logic                     start;

    // Settings in force for the receiver
    rxcfg_pkg::rx_mode_e      act_mode_r;
    rxcfg_pkg::rx_mode_e      act_mode_nxt;
    logic                     act_bae_r;
    logic                     act_bae_nxt;
    logic                     act_drop_r;
    logic                     act_drop_nxt;
    logic [7:0]               act_pat_r;
    logic [7:0]               act_pat_nxt;

    logic [7:0]               rdata_r;
    logic [7:0]               rdata_nxt;
    logic [7:0]               cfg_view;
    logic [7:0]               fdata_r;
    logic [7:0]               fdata_nxt;
    logic                     fwr_r;
    logic                     fwr_nxt;

    logic [7:0]               al_byte;
    logic                     al_valid;
    logic [7:0]               tr_byte;
    logic                     tr_valid;

    rxcfg_if cfg_bus ();

    assign cfg_wr = ce && reg_wr && reg_addr == `RXC_ADDR_CFG;
    assign pat_wr = ce && reg_wr && reg_addr == `RXC_ADDR_PAT;
    assign start  = cfg_wr && reg_wdata[`RXC_BIT_INIT]; // [RQ5]
    assign busy   = state_r == rxcfg_pkg::INIT_RUN;

    // Upper bits are not stored, so they always read zero
    always_comb begin
        mode_nxt = mode_r;
        bae_nxt  = bae_r;
        drop_nxt = drop_r;
        pat_nxt  = pat_r;
        if (cfg_wr) begin
            mode_nxt = rxcfg_pkg::rx_mode_e'(reg_wdata[`RXC_BIT_MODE]);
            bae_nxt  = reg_wdata[`RXC_BIT_BAE];
            drop_nxt = reg_wdata[`RXC_BIT_DROP];
        end
        if (pat_wr) begin
            pat_nxt = reg_wdata; // [RQ3]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= rxcfg_pkg::rx_mode_e'(CFG_RST[`RXC_BIT_MODE]);
            bae_r  <= CFG_RST[`RXC_BIT_BAE];
            drop_r <= CFG_RST[`RXC_BIT_DROP];
            pat_r  <= PAT_RST;
        end else begin
            mode_r <= mode_nxt;
            bae_r  <= bae_nxt;
            drop_r <= drop_nxt;
            pat_r  <= pat_nxt;
        end
    end

    // A new start while running restarts the count
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            rxcfg_pkg::INIT_IDLE: begin
                if (start) begin
                    state_nxt = rxcfg_pkg::INIT_RUN; // [RQ5]
                    cnt_nxt   = '0;
                end
            end
            rxcfg_pkg::INIT_RUN: begin
                if (start) begin
                    cnt_nxt = '0;
                end else if (cnt_r == CNT_LAST) begin
                    state_nxt = rxcfg_pkg::INIT_IDLE; // [RQ7]
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = rxcfg_pkg::INIT_RUN;
                cnt_nxt   = '0;
            end
        endcase
    end

    // Reset lands in the running state: power-up init needs no write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= rxcfg_pkg::INIT_RUN; // [RQ6]
            cnt_r   <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Settings follow the registers only during init
    always_comb begin
        act_mode_nxt = act_mode_r;
        act_bae_nxt  = act_bae_r;
        act_drop_nxt = act_drop_r;
        act_pat_nxt  = act_pat_r;
        if (busy) begin
            act_mode_nxt = mode_r; // [RQ1]
            act_bae_nxt  = bae_r; // [RQ2]
            act_drop_nxt = drop_r; // [RQ10]
            act_pat_nxt  = pat_r; // [RQ3]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_mode_r <= rxcfg_pkg::rx_mode_e'(CFG_RST[`RXC_BIT_MODE]);
            act_bae_r  <= CFG_RST[`RXC_BIT_BAE];
            act_drop_r <= CFG_RST[`RXC_BIT_DROP];
            act_pat_r  <= PAT_RST;
        end else if (ce) begin
            act_mode_r <= act_mode_nxt;
            act_bae_r  <= act_bae_nxt;
            act_drop_r <= act_drop_nxt;
            act_pat_r  <= act_pat_nxt;
        end
    end

    always_comb begin
        cfg_view                = 8'h00;
        cfg_view[`RXC_BIT_MODE] = mode_r;
        cfg_view[`RXC_BIT_BAE]  = bae_r;
        cfg_view[`RXC_BIT_DROP] = drop_r;
        cfg_view[`RXC_BIT_INIT] = busy; // [RQ7]
    end

    // Read data live for one cycle only
    always_comb begin
        rdata_nxt = 8'h00;
        if (ce && reg_rd) begin
            case (reg_addr)
                `RXC_ADDR_CFG: rdata_nxt = cfg_view;
                `RXC_ADDR_PAT: rdata_nxt = pat_r;
                default:       rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg_bus.mode    = act_mode_r;
    assign cfg_bus.bae     = act_bae_r;
    assign cfg_bus.drop    = act_drop_r;
    assign cfg_bus.pattern = act_pat_r;
    assign cfg_bus.clear   = busy;
    assign cfg_bus.ce      = ce;

    byte_aligner u_align (
        .clk        (clk),
        .resetn     (resetn),
        .cfg        (cfg_bus.user),
        .bit_in     (rx_bit),
        .bit_valid  (rx_bit_valid),
        .byte_out   (al_byte),
        .byte_valid (al_valid)
    );

    crc_trimmer u_trim (
        .clk           (clk),
        .resetn        (resetn),
        .cfg           (cfg_bus.user),
        .byte_in       (rx_byte),
        .byte_in_valid (rx_byte_valid),
        .frame_end     (rx_frame_end),
        .byte_out      (tr_byte),
        .byte_valid    (tr_valid)
    );

    // Only the path for the latched mode reaches the FIFO
    always_comb begin
        fdata_nxt = fdata_r;
        fwr_nxt   = 1'b0;
        if (!busy) begin
            if (act_mode_r == rxcfg_pkg::RX_MODE_TRANSP) begin
                fwr_nxt = al_valid; // [RQ1]
                if (al_valid) begin
                    fdata_nxt = al_byte;
                end
            end else begin
                fwr_nxt = tr_valid; // [RQ1]
                if (tr_valid) begin
                    fdata_nxt = tr_byte;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fdata_r <= 8'h00;
            fwr_r   <= 1'b0;
        end else if (ce) begin
            fdata_r <= fdata_nxt;
            fwr_r   <= fwr_nxt;
        end
    end

    assign reg_rdata    = rdata_r;
    assign fifo_wdata   = fdata_r;
    assign fifo_wr      = fwr_r;
    assign rx_init_busy = busy;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence init_request;
        cfg_wr && reg_wdata[`RXC_BIT_INIT];
    endsequence

    sequence init_final_step;
        ce && busy && !start && cnt_r == CNT_LAST;
    endsequence

    chk_init_start: assert property ( // [RQ5]
        init_request |=> busy && cnt_r == '0)
        else $error("Init write did not start initialization");

    chk_zero_ignored: assert property ( // [RQ5]
        cfg_wr && !reg_wdata[`RXC_BIT_INIT] && !busy |=> !busy)
        else $error("Writing zero to init bit started init");

    chk_powerup_init: assert property ( // [RQ6]
        $rose(resetn) |-> busy && cnt_r == '0)
        else $error("No automatic init after reset");

    chk_init_holds: assert property ( // [RQ7]
        ce && busy && !start && cnt_r != CNT_LAST |=> busy)
        else $error("Init ended before its count");

    chk_init_ends: assert property ( // [RQ7]
        $fell(busy) |-> $past(cnt_r) == CNT_LAST)
        else $error("Init did not end on time");

    chk_init_clears: assert property ( // [RQ7]
        init_final_step |=> !busy)
        else $error("Init bit not cleared after init");

    chk_busy_readback: assert property ( // [RQ7]
        ce && reg_rd && reg_addr == `RXC_ADDR_CFG
        |=> reg_rdata[`RXC_BIT_INIT] == $past(busy)
            && reg_rdata[7:4] == 4'h0)
        else $error("Config read shows wrong init bit");

    chk_drop_frozen: assert property ( // [RQ10]
        !busy |=> $stable(act_drop_r) && $stable(act_mode_r))
        else $error("Latched setting changed outside init");

    chk_hdlc_pass: assert property ( // [RQ4]
        ce && !busy && act_mode_r == rxcfg_pkg::RX_MODE_HDLC
        && !act_drop_r && rx_byte_valid && !rx_frame_end
        |=> fifo_wr && fifo_wdata == $past(rx_byte))
        else $error("HDLC byte not written to FIFO");

    chk_quiet_in_init: assert property ( // [RQ5]
        ce && busy |=> !fifo_wr)
        else $error("FIFO written during initialization");

endmodule

/* File: rtl/rxcfg_defs.svh */
`ifndef RXCFG_DEFS_SVH
`define RXCFG_DEFS_SVH

`define RXC_ADDR_CFG     8'h19
`define RXC_ADDR_PAT     8'h22
`define RXC_CFG_RESET    8'h02
`define RXC_PAT_RESET    8'h7E
`define RXC_BIT_INIT     0
`define RXC_BIT_DROP     1
`define RXC_BIT_BAE      2
`define RXC_BIT_MODE     3
`define RXC_INIT_CYCLES  16
`define RXC_CRC_BYTES    2

`endif

/* File: rtl/rxcfg_if.sv */
`timescale 1ns/1ps

interface rxcfg_if;
    rxcfg_pkg::rx_mode_e mode;
    logic                bae;
    logic                drop;
    logic [7:0]          pattern;
    logic                clear;
    logic                ce;

    modport ctrl (
        output mode,
        output bae,
        output drop,
        output pattern,
        output clear,
        output ce
    );

    modport user (
        input  mode,
        input  bae,
        input  drop,
        input  pattern,
        input  clear,
        input  ce
    );
endinterface

/* File: rtl/rxcfg_pkg.sv */
package rxcfg_pkg;

    typedef enum logic {
        RX_MODE_HDLC   = 1'b0,
        RX_MODE_TRANSP = 1'b1
    } rx_mode_e;

    typedef enum logic [1:0] {
        INIT_IDLE = 2'b01,
        INIT_RUN  = 2'b10
    } init_state_e;

endpackage

/* File: testbench/fw_host_model.sv */
`timescale 1ns/1ps
`include "rxcfg_defs.svh"

module fw_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Released lines flip so stale values never pass for valid ones
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    // New settings are only trusted after a fresh init has finished
    task automatic start_init(input logic [7:0] cfg, output logic [7:0] first,
                              output int polls);
        logic [7:0] d;
        reg_write(`RXC_ADDR_CFG, (cfg & 8'h0F) | 8'h01);
        polls = 0;
        reg_read(`RXC_ADDR_CFG, first);
        d = first;
        while (d[0] !== 1'b0 && polls < 64) begin
            polls++;
            reg_read(`RXC_ADDR_CFG, d);
        end
        if (d[0] !== 1'b0) begin
            polls = -1;
        end
    endtask
endmodule

/* File: testbench/hdlc_receiver_config_init_tb.sv */
`timescale 1ns/1ps
`include "rxcfg_defs.svh"

module hdlc_receiver_config_init_tb;
    localparam int INIT_N = 4;
    logic       clk;
    logic       resetn;
    logic       ce;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte, fifo_wdata;
    logic       reg_wr, reg_rd, rx_bit, rx_bit_valid, rx_byte_valid;
    logic       rx_frame_end, fifo_wr, rx_init_busy;
    int         num_errors = 0;
    int         n_tests = 0;
    logic [7:0] got_q[$];

    hdlc_receiver_config_init #(
        .INIT_CYCLES(INIT_N)
    ) u_hdlc_receiver_config_init (
        .clk(clk), .resetn(resetn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
        .fifo_wdata(fifo_wdata), .fifo_wr(fifo_wr),
        .rx_init_busy(rx_init_busy)
    );

    fw_host_model u_fw_host_model (
        .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    always @(posedge clk) begin
        if (fifo_wr === 1'b1) begin
            got_q.push_back(fifo_wdata);
        end
    end

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_fifo(input logic [31:0] exp, input int n);
        chk8("fifo count", 8'(n), 8'(got_q.size()));
        for (int i = 0; i < n && i < got_q.size(); i++) begin
            chk8("fifo byte", exp[8*i +: 8], got_q[i]);
        end
        got_q.delete();
    endtask

    // Four bytes back to back, end-of-frame pulse right after the last
    task automatic send_frame(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rx_byte       <= w[8*i +: 8];
            rx_byte_valid <= 1'b1;
        end
        @(posedge clk);
        rx_byte_valid <= 1'b0;
        rx_byte       <= ~w[31:24];
        rx_frame_end  <= 1'b1;
        @(posedge clk);
        rx_frame_end  <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic send_bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_bit       <= v[i];
            rx_bit_valid <= 1'b1;
        end
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic do_init(input logic [7:0] cfg);
        logic [7:0] first;
        int         polls;
        u_fw_host_model.start_init(cfg, first, polls);
        chk8("init bit while busy", 8'h01, {7'h00, first[0]});
        chk8("init bit cleared", 8'h01, {7'h00, polls >= 0});
        got_q.delete();
    endtask

    task automatic t_power_up;
        int k;
        // Flops may miss the time-zero reset edge; let clocks pass first
        repeat (9) @(posedge clk);
        #1;
        chk8("busy in reset", 8'h01, {7'h00, rx_init_busy});
        chk8("rdata in reset", 8'h00, reg_rdata);
        @(posedge clk);
        resetn <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (rx_init_busy !== 1'b0 && k < 40);
        chk8("auto init edges", 8'(INIT_N), 8'(k));
    endtask

    task automatic t_registers;
        logic [7:0] d;
        u_fw_host_model.reg_read(`RXC_ADDR_CFG, d);
        chk8("config reset", `RXC_CFG_RESET, d);
        u_fw_host_model.reg_read(`RXC_ADDR_PAT, d);
        chk8("pattern reset", `RXC_PAT_RESET, d);
        u_fw_host_model.reg_read(8'h40, d);
        chk8("unmapped read", 8'h00, d);
        u_fw_host_model.reg_write(`RXC_ADDR_CFG, 8'h0A);
        #1;
        chk8("busy after zero", 8'h00, {7'h00, rx_init_busy});
        u_fw_host_model.reg_read(`RXC_ADDR_CFG, d);
        chk8("config zero init", 8'h0A, d);
        // An init write with the clock enable low must be ignored
        @(posedge clk);
        ce <= 1'b0;
        u_fw_host_model.reg_write(`RXC_ADDR_CFG, 8'h05);
        ce <= 1'b1;
        #1;
        chk8("busy after ce low", 8'h00, {7'h00, rx_init_busy});
        u_fw_host_model.reg_read(`RXC_ADDR_CFG, d);
        chk8("config ce low", 8'h0A, d);
    endtask

    task automatic t_hdlc_keep_crc;
        do_init(8'h00);
        send_frame(32'h44332211);
        check_fifo(32'h44332211, 4);
    endtask

    // Drop is cleared after init without a new init: must stay dropping
    task automatic t_hdlc_drop_latched;
        do_init(8'h02);
        u_fw_host_model.reg_write(`RXC_ADDR_CFG, 8'h00);
        send_frame(32'hD4C3B2A1);
        check_fifo(32'h0000B2A1, 2);
    endtask

    task automatic t_transparent;
        do_init(8'h08);
        send_bits(32'h0000A55A, 16);
        check_fifo(32'h0000A55A, 2);
    endtask

    // Junk ones, then the pattern, then one data byte
    task automatic t_align;
        u_fw_host_model.reg_write(`RXC_ADDR_PAT, 8'h3C);
        do_init(8'h0C);
        send_bits(32'({8'h5A, 8'h3C, 3'b111}), 19);
        check_fifo(32'h0000005A, 1);
    endtask

    initial begin
        resetn        = 1'b0;
        ce            = 1'b1;
        rx_bit        = 1'b0;
        rx_bit_valid  = 1'b0;
        rx_byte       = 8'h00;
        rx_byte_valid = 1'b0;
        rx_frame_end  = 1'b0;
        #1;
        t_power_up;
        t_registers;
        t_hdlc_keep_crc;
        t_hdlc_drop_latched;
        t_transparent;
        t_align;
        stop_test;
    end

    initial begin
        #(40 * 20000);
        num_errors++;
        stop_test;
    end
endmodule
